// *** logic/asl_pkg.sv ***
// shared constants, register map and helpers for the serial lvds output link
package asl_pkg;
    localparam int NUM_LANES = 8;
    localparam int WORD_W = 12;
    localparam int HALF_WORD = WORD_W / 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // timing, clk is 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_CYC = 4;
    localparam int HALF_BIT = BIT_CYC / 2;
    localparam int SCLK_HALF_CYC = BIT_CYC * WORD_W / 2;
    localparam int SCLK_MIN_KHZ = 3000;
    localparam int STOP_NS = 1000000 / SCLK_MIN_KHZ;
    localparam int STOP_CYC = STOP_NS / CLK_PERIOD_NS;
    localparam int SHORT_STOP_NS = 300;
    localparam int SHORT_STOP_CYC = SHORT_STOP_NS / CLK_PERIOD_NS;
    localparam int RELOCK_US = 10;
    localparam int RELOCK_CYC = RELOCK_US * 1000 / CLK_PERIOD_NS;
    localparam int CLKSTOP_REC_US = 100;
    localparam int CLKSTOP_REC_CYC_DEF = CLKSTOP_REC_US * 1000 / CLK_PERIOD_NS;
    localparam int PD_REC_US = 500;
    localparam int PD_REC_CYC_DEF = PD_REC_US * 1000 / CLK_PERIOD_NS;
    localparam int RST_PULSE_CYC = 8;
    localparam int EDGE_TO_CYC = 4 * BIT_CYC;
    // device registers
    localparam logic [7:0] DEV_CTRL = 8'h00;
    localparam logic [7:0] DEV_PATTERN = 8'h04;
    localparam logic [7:0] DEV_CH_PDN = 8'h08;
    localparam logic [7:0] DEV_STATUS = 8'h0c;
    localparam int CTRL_MSB_FIRST = 0;
    localparam int CTRL_DESKEW = 1;
    localparam int CTRL_SYNC = 2;
    localparam int CTRL_CUSTOM = 3;
    localparam int CTRL_DRIVE_LSB = 4;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    localparam int STAT_PD_PIN = 0;
    localparam int STAT_CLK_STOP = 1;
    localparam int STAT_PD = 2;
    localparam logic [1:0] DRV_3P5MA = 2'h0;
    // patterns in transmit order, bit 0 goes out first
    localparam logic [WORD_W-1:0] PAT_DESKEW = 12'haaa;
    localparam logic [WORD_W-1:0] PAT_SYNC = 12'hfc0;
    // host registers
    localparam logic [7:0] HST_CTRL = 8'h00;
    localparam logic [7:0] HST_CMD = 8'h04;
    localparam logic [7:0] HST_STATUS = 8'h08;
    localparam logic [7:0] HST_DATA = 8'h20;
    localparam int HC_PD = 0;
    localparam int HC_SCLK_STOP = 1;
    localparam int HC_MSB_FIRST = 2;
    localparam int HS_READY = 0;
    localparam int HS_LOCK = 1;
    localparam int HS_HOLD = 2;

    typedef logic [NUM_LANES-1:0][WORD_W-1:0] asl_words_t;

    function automatic logic [WORD_W-1:0] asl_reverse(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] r;
        r = '0;
        for (int i = 0; i < WORD_W; i++) begin
            r[i] = w[WORD_W-1-i];
        end
        return r;
    endfunction : asl_reverse
endpackage : asl_pkg

// *** logic/asl_link_if.sv ***
// link between the serializing device end and the receiving end
`timescale 1ns/10ps
interface asl_link_if;
    import asl_pkg::*;
    logic bclk_p;
    logic bclk_n;
    logic bclk_oe;
    logic fclk_p;
    logic fclk_n;
    logic fclk_oe;
    logic [NUM_LANES-1:0] lane_p;
    logic [NUM_LANES-1:0] lane_n;
    logic [NUM_LANES-1:0] lane_oe;
    logic [1:0] drive;
    logic power_down_pin;
    logic reset_pin;
    logic sample_clock_input;
    // a released driver reads as low at the receiver
    logic bclk_rx;
    logic fclk_rx;
    logic [NUM_LANES-1:0] lane_rx;
    assign bclk_rx = bclk_oe & bclk_p;
    assign fclk_rx = fclk_oe & fclk_p;
    assign lane_rx = lane_oe & lane_p;

    modport dev (
        output bclk_p, bclk_n, bclk_oe, fclk_p, fclk_n, fclk_oe,
        output lane_p, lane_n, lane_oe, drive,
        input power_down_pin, reset_pin, sample_clock_input
    );
    modport host (
        input bclk_rx, fclk_rx, lane_rx,
        output power_down_pin, reset_pin, sample_clock_input
    );
endinterface : asl_link_if

// *** logic/asl_dev.sv ***
// device end: eight-lane serializer with bit clock, frame clock and test patterns
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module asl_dev
    import asl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    asl_link_if.dev link,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // converter words, taken at each frame start
    input wire asl_words_t conv_data
);
    import asl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic sclk_prev_q;
    logic pd_pin;
    logic rst_pin;
    logic sclk_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
            sclk_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= {link.sample_clock_input, link.reset_pin, link.power_down_pin};
            pin_sync_q <= pin_meta_q;
            sclk_prev_q <= pin_sync_q[2];
        end
    end

    assign pd_pin = pin_sync_q[0];
    assign rst_pin = pin_sync_q[1];
    assign sclk_s = pin_sync_q[2];

    ////////////////////////////////////////////////////////////////////////
    // sample clock monitor
    logic [7:0] stop_cnt_q;
    logic clk_stop;
    logic power_down;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_cnt_q <= 8'(STOP_CYC);
        // either edge restarts the count: a frame-rate sample clock has rising edges further apart than the limit
        end else if (sclk_s != sclk_prev_q) begin
            stop_cnt_q <= 8'h00;
        end else if (stop_cnt_q != 8'(STOP_CYC)) begin
            stop_cnt_q <= stop_cnt_q + 8'h01;
        end
    end

    // starts stopped so that nothing drives until the sample clock shows up
    assign clk_stop = (stop_cnt_q == 8'(STOP_CYC));
    assign power_down = pd_pin | clk_stop;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [CTRL_W-1:0] ctrl_q;
    logic [WORD_W-1:0] pattern_q;
    logic [NUM_LANES-1:0] ch_pdn_q;
    logic [DATA_W-1:0] rdata_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            pattern_q <= '0;
            ch_pdn_q <= '0;
        end else if (rst_pin) begin
            ctrl_q <= CTRL_RESET;
            pattern_q <= '0;
            ch_pdn_q <= '0;
        end else if (reg_wr) begin
            if (reg_addr == DEV_CTRL) begin
                ctrl_q <= reg_wdata[CTRL_W-1:0];
            end
            if (reg_addr == DEV_PATTERN) begin
                pattern_q <= reg_wdata[WORD_W-1:0];
            end
            if (reg_addr == DEV_CH_PDN) begin
                ch_pdn_q <= reg_wdata[NUM_LANES-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                DEV_CTRL: begin
                    rdata_q <= DATA_W'(ctrl_q);
                end
                DEV_PATTERN: begin
                    rdata_q <= DATA_W'(pattern_q);
                end
                DEV_CH_PDN: begin
                    rdata_q <= DATA_W'(ch_pdn_q);
                end
                DEV_STATUS: begin
                    rdata_q <= '0;
                    rdata_q[STAT_PD_PIN] <= pd_pin;
                    rdata_q[STAT_CLK_STOP] <= clk_stop;
                    rdata_q[STAT_PD] <= power_down;
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // bit and frame timing, reset only by rst_n so clocks run through rst_pin
    logic [1:0] phase_q;
    logic [3:0] bit_q;
    logic bit_end;
    logic [3:0] next_bit;

    assign bit_end = (phase_q == 2'(BIT_CYC - 1));
    assign next_bit = (bit_q == 4'(WORD_W - 1)) ? 4'h0 : bit_q + 4'h1;

    // divider stands in for the multiplying loop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
            bit_q <= 4'h0;
        end else begin
            phase_q <= bit_end ? 2'h0 : phase_q + 2'h1;
            if (bit_end) begin
                bit_q <= next_bit;
            end
        end
    end

    logic bclk_q;
    logic fclk_q;
    logic clk_oe_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_q <= 1'b0;
            fclk_q <= 1'b0;
            clk_oe_q <= 1'b0;
        end else begin
            // one edge per bit, centred in the bit
            if (phase_q == 2'(HALF_BIT - 1)) begin
                bclk_q <= ~bclk_q;
            end
            // high over first half of the word
            if (bit_end) begin
                fclk_q <= (next_bit < 4'(HALF_WORD));
            end
            clk_oe_q <= ~power_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // word selection and serializer
    logic [CTRL_W-1:0] mode;
    logic [NUM_LANES-1:0] lane_p_q;
    logic [NUM_LANES-1:0] lane_n_q;
    logic [NUM_LANES-1:0] lane_oe_q;
    logic [1:0] drive_q;
    asl_words_t sh_q;
    asl_words_t word;

    assign mode = ctrl_q;

    always_comb begin
        for (int i = 0; i < NUM_LANES; i++) begin
            // zero code while reset pin held
            if (rst_pin || power_down || ch_pdn_q[i]) begin
                word[i] = '0;
            end else if (mode[CTRL_DESKEW]) begin
                word[i] = PAT_DESKEW;
            end else if (mode[CTRL_SYNC]) begin
                word[i] = PAT_SYNC;
            end else if (mode[CTRL_CUSTOM]) begin
                word[i] = pattern_q;
            end else if (mode[CTRL_MSB_FIRST]) begin
                word[i] = asl_reverse(conv_data[i]);
            end else begin
                word[i] = conv_data[i];
            end
        end
    end

    // every lane loads at the frame start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= '0;
            lane_p_q <= '0;
            lane_n_q <= '1;
        end else if (bit_end) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                if (next_bit == 4'h0) begin
                    lane_p_q[i] <= word[i][0];
                    lane_n_q[i] <= ~word[i][0];
                    sh_q[i] <= word[i] >> 1;
                end else begin
                    lane_p_q[i] <= sh_q[i][0];
                    lane_n_q[i] <= ~sh_q[i][0];
                    sh_q[i] <= sh_q[i] >> 1;
                end
            end
        end
    end

    // a powered-down channel releases its lane
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lane_oe_q <= '0;
        end else begin
            lane_oe_q <= ~(ch_pdn_q | {NUM_LANES{power_down}});
        end
    end

    // drive setting, 3.5mA code after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q <= DRV_3P5MA;
        end else begin
            drive_q <= ctrl_q[CTRL_DRIVE_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin outputs
    assign link.bclk_p = bclk_q;
    assign link.bclk_n = ~bclk_q;
    assign link.bclk_oe = clk_oe_q;
    assign link.fclk_p = fclk_q;
    assign link.fclk_n = ~fclk_q;
    assign link.fclk_oe = clk_oe_q;
    assign link.lane_p = lane_p_q;
    assign link.lane_n = lane_n_q;
    assign link.lane_oe = lane_oe_q;
    assign link.drive = drive_q;
endmodule : asl_dev

// *** logic/asl_host.sv ***
// receiving end: drives control pins, deserializes lanes, tracks recovery wait
`timescale 1ns/10ps
module asl_host
    import asl_pkg::*;
#(
    parameter int PD_REC_CYC = asl_pkg::PD_REC_CYC_DEF,
    parameter int CLKSTOP_REC_CYC = asl_pkg::CLKSTOP_REC_CYC_DEF
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    asl_link_if.host link,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata
);
    import asl_pkg::*;

    typedef enum logic {ASL_HS_RESET, ASL_HS_RUN} asl_hstate_t;

    ////////////////////////////////////////////////////////////////////////
    // control register and reset pulse
    logic [2:0] ctrl_q;
    asl_hstate_t state_q;
    logic [3:0] rst_cnt_q;
    logic cmd_reset;

    assign cmd_reset = reg_wr && (reg_addr == HST_CMD) && reg_wdata[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 3'h0;
        end else if (reg_wr && reg_addr == HST_CTRL) begin
            ctrl_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ASL_HS_RESET;
            rst_cnt_q <= 4'h0;
        end else begin
            case (state_q)
                ASL_HS_RESET: begin
                    rst_cnt_q <= rst_cnt_q + 4'h1;
                    if (rst_cnt_q == 4'(RST_PULSE_CYC - 1)) begin
                        state_q <= ASL_HS_RUN;
                    end
                end
                ASL_HS_RUN: begin
                    rst_cnt_q <= 4'h0;
                    if (cmd_reset) begin
                        state_q <= ASL_HS_RESET;
                    end
                end
                default: begin
                    state_q <= ASL_HS_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample clock, power-down pin and recovery hold-off
    logic [5:0] sclk_cnt_q;
    logic sclk_q;
    logic pd_q;
    logic rst_pin_q;
    logic [5:0] stop_len_q;
    logic stop_prev_q;
    logic [15:0] hold_q;
    logic [15:0] hold_load;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_cnt_q <= 6'h00;
            sclk_q <= 1'b0;
            stop_len_q <= 6'h00;
            stop_prev_q <= 1'b0;
            pd_q <= 1'b0;
            rst_pin_q <= 1'b0;
        end else begin
            stop_prev_q <= ctrl_q[HC_SCLK_STOP];
            pd_q <= ctrl_q[HC_PD];
            rst_pin_q <= (state_q == ASL_HS_RESET);
            if (ctrl_q[HC_SCLK_STOP]) begin
                if (stop_len_q != 6'(SHORT_STOP_CYC)) begin
                    stop_len_q <= stop_len_q + 6'h01;
                end
            end else begin
                stop_len_q <= 6'h00;
                sclk_cnt_q <= (sclk_cnt_q == 6'(SCLK_HALF_CYC - 1)) ? 6'h00 : sclk_cnt_q + 6'h01;
                if (sclk_cnt_q == 6'(SCLK_HALF_CYC - 1)) begin
                    sclk_q <= ~sclk_q;
                end
            end
        end
    end

    always_comb begin
        hold_load = 16'h0000;
        if (pd_q && !ctrl_q[HC_PD]) begin
            hold_load = 16'(PD_REC_CYC);
        end else if (stop_prev_q && !ctrl_q[HC_SCLK_STOP]) begin
            hold_load = (stop_len_q < 6'(SHORT_STOP_CYC)) ? 16'(RELOCK_CYC) : 16'(CLKSTOP_REC_CYC);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= 16'h0000;
        end else if (hold_load > hold_q) begin
            hold_q <= hold_load;
        end else if (hold_q != 16'h0000) begin
            hold_q <= hold_q - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // deserializer on the synchronised bit clock
    logic [NUM_LANES+1:0] rx_meta_q;
    logic [NUM_LANES+1:0] rx_sync_q;
    logic bclk_prev_q;
    logic fclk_prev_q;
    logic [3:0] idx_q;
    logic [4:0] to_q;
    logic lock_q;
    asl_words_t acc_q;
    asl_words_t data_q;
    logic bclk_edge;
    logic fstart;
    logic [3:0] nidx;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= '0;
            rx_sync_q <= '0;
        end else begin
            rx_meta_q <= {link.fclk_rx, link.bclk_rx, link.lane_rx};
            rx_sync_q <= rx_meta_q;
        end
    end

    assign bclk_edge = rx_sync_q[NUM_LANES] ^ bclk_prev_q;
    // word starts where frame clock rises
    assign fstart = rx_sync_q[NUM_LANES+1] && !fclk_prev_q;
    assign nidx = fstart ? 4'h0 : idx_q + 4'h1;

    // capture on every bit clock edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_prev_q <= 1'b0;
            fclk_prev_q <= 1'b0;
            idx_q <= 4'h0;
            to_q <= 5'h00;
            lock_q <= 1'b0;
            acc_q <= '0;
            data_q <= '0;
        end else begin
            bclk_prev_q <= rx_sync_q[NUM_LANES];
            to_q <= bclk_edge ? 5'h00 : (to_q == 5'(EDGE_TO_CYC) ? to_q : to_q + 5'h01);
            if (to_q == 5'(EDGE_TO_CYC)) begin
                lock_q <= 1'b0;
            end
            if (bclk_edge) begin
                fclk_prev_q <= rx_sync_q[NUM_LANES+1];
                idx_q <= nidx;
                if (fstart) begin
                    lock_q <= (idx_q == 4'(WORD_W - 1));
                end
                for (int i = 0; i < NUM_LANES; i++) begin
                    acc_q[i] <= {rx_sync_q[i], acc_q[i][WORD_W-1:1]};
                    if (nidx == 4'(WORD_W - 1)) begin
                        data_q[i] <= ctrl_q[HC_MSB_FIRST] ? asl_reverse({rx_sync_q[i], acc_q[i][WORD_W-1:1]})
                                                          : {rx_sync_q[i], acc_q[i][WORD_W-1:1]};
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads and pins
    logic [DATA_W-1:0] rdata_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (!reg_rd) begin
            rdata_q <= '0;
        end else if (reg_addr == HST_CTRL) begin
            rdata_q <= DATA_W'(ctrl_q);
        end else if (reg_addr == HST_STATUS) begin
            rdata_q <= '0;
            rdata_q[HS_READY] <= (state_q == ASL_HS_RUN) && (hold_q == 16'h0000) && lock_q;
            rdata_q[HS_LOCK] <= lock_q;
            rdata_q[HS_HOLD] <= (hold_q != 16'h0000);
        end else if (reg_addr[7:5] == HST_DATA[7:5] && reg_addr[1:0] == 2'h0) begin
            rdata_q <= DATA_W'(data_q[reg_addr[4:2]]);
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;
    assign link.power_down_pin = pd_q;
    assign link.reset_pin = rst_pin_q;
    assign link.sample_clock_input = sclk_q;
endmodule : asl_host

// *** dv/asl_link_sva.sv ***
// link checker: clock shapes, power-down release and reset effects
`timescale 1ns/10ps
module asl_link_sva
    import asl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    input wire logic bclk_p,
    input wire logic bclk_oe,
    input wire logic fclk_p,
    input wire logic fclk_oe,
    input wire logic [NUM_LANES-1:0] lane_oe,
    input wire logic [1:0] drive,
    input wire logic power_down_pin,
    input wire logic reset_pin,
    input wire logic sample_clock_input
);
    logic sclk_q;
    logic [7:0] idle_q;
    // cycles since the sample clock last moved, saturating so it never wraps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            idle_q <= 8'h00;
        end else begin
            sclk_q <= sample_clock_input;
            idle_q <= (sample_clock_input != sclk_q) ? 8'h00 : idle_q + 8'(idle_q != 8'hff);
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_frame;
        $rose(fclk_p) && fclk_oe;
    endsequence
    a_frame_width: assert property (s_frame |-> ##24 ($fell(fclk_p) || !fclk_oe))
        else $error("frame clock width");
    a_bit_phase: assert property (s_frame |-> ##2 ($changed(bclk_p) || !bclk_oe))
        else $error("bit clock phase");
    a_bit_half: assert property ($rose(bclk_p) && bclk_oe |-> ##4 ($fell(bclk_p) || !bclk_oe))
        else $error("bit clock half period");
    a_pd_release: assert property ($rose(power_down_pin) |-> ##[1:8] (lane_oe == '0 && !bclk_oe && !fclk_oe))
        else $error("drivers not released");
    a_pd_hold: assert property (power_down_pin [*8] |-> lane_oe == '0 && !fclk_oe)
        else $error("driving in power-down");
    a_clock_stop: assert property (idle_q > 8'd120 |-> lane_oe == '0 && !fclk_oe)
        else $error("driving with stopped clock");
    a_drive_reset: assert property ($rose(reset_pin) |-> ##[1:6] drive == 2'h0)
        else $error("drive not cleared");
    a_clocks_in_reset: assert property (reset_pin && fclk_oe |-> ##[1:25] ($changed(fclk_p) || !fclk_oe))
        else $error("frame clock stalled");
endmodule : asl_link_sva

// *** dv/tb.sv ***
// testbench: both link ends joined, received words compared with a model
`timescale 1ns/10ps
module tb;
    import asl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [1:0] ws = 2'h0;
    logic [1:0] rs = 2'h0;
    logic [31:0] d_rdata;
    logic [31:0] h_rdata;
    logic [31:0] v;
    logic [11:0] p;
    asl_words_t conv = '0;
    logic [11:0] exp_w [NUM_LANES];
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int seed = 32'hda86;
    int ch;
    asl_link_if lk ();
    asl_dev i_asl_dev (.clk(clk), .rst_n(rst_n), .link(lk), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(ws[0]), .reg_rd(rs[0]), .reg_rdata(d_rdata), .conv_data(conv));
    asl_host #(.PD_REC_CYC(200), .CLKSTOP_REC_CYC(100)) i_asl_host (.clk(clk), .rst_n(rst_n), .link(lk),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(ws[1]), .reg_rd(rs[1]), .reg_rdata(h_rdata));
    asl_link_sva i_asl_link_sva (.clk(clk), .rst_n(rst_n), .bclk_p(lk.bclk_p), .bclk_oe(lk.bclk_oe),
        .fclk_p(lk.fclk_p), .fclk_oe(lk.fclk_oe), .lane_oe(lk.lane_oe), .drive(lk.drive),
        .power_down_pin(lk.power_down_pin), .reset_pin(lk.reset_pin), .sample_clock_input(lk.sample_clock_input));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_total++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input int s, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        ws[s] <= 1'b1;
        @(posedge clk);
        ws <= 2'h0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input int s, input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rs[s] <= 1'b1;
        @(posedge clk);
        rs <= 2'h0;
        #1;
        v = s ? h_rdata : d_rdata;
    endtask : rd
    task automatic wait_rdy();
        v = '0;
        for (int i = 0; i < 3000 && v[HS_READY] !== 1'b1; i++) begin
            rd(1, HST_STATUS);
        end
        chk(v & 32'h1, 32'h1);
    endtask : wait_rdy
    // four frames, so a word taken after a change is whole
    task automatic settle();
        repeat (192) @(posedge clk);
    endtask : settle
    task automatic words();
        for (int i = 0; i < NUM_LANES; i++) begin
            rd(1, HST_DATA + 8'(4 * i));
            chk(v & 32'hfff, 32'(exp_w[i]));
        end
    endtask : words
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(0, DEV_CTRL);
        chk(v, 32'h0);
        rd(0, 8'h40);
        chk(v, 32'h0);
        wait_rdy();
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            for (int i = 0; i < NUM_LANES; i++) begin
                conv[i] <= 12'($random(seed));
            end
            wr(0, DEV_CTRL, 32'(m > 0));
            wr(1, HST_CTRL, (m == 2) ? 32'h4 : 32'h0);
            settle();
            for (int i = 0; i < NUM_LANES; i++) begin
                exp_w[i] = conv[i];
                if (m == 1) begin
                    exp_w[i] = {<<{conv[i]}};
                end
            end
            words();
        end
        p = 12'($random(seed));
        wr(1, HST_CTRL, 32'h0);
        wr(0, DEV_PATTERN, 32'(p));
        for (int m = 1; m < 4; m++) begin
            wr(0, DEV_CTRL, 32'(1 << m));
            settle();
            for (int i = 0; i < NUM_LANES; i++) begin
                exp_w[i] = (m == 1) ? PAT_DESKEW : (m == 2) ? PAT_SYNC : p;
            end
            words();
        end
        ch = {$random(seed)} % NUM_LANES;
        p = 12'($random(seed));
        wr(0, DEV_CTRL, 32'(p[1:0]) << CTRL_DRIVE_LSB);
        wr(0, DEV_CH_PDN, 32'h1 << ch);
        settle();
        chk(32'(lk.drive), 32'(p[1:0]));
        chk(32'(lk.lane_oe) ^ 32'hff, 32'h1 << ch);
        for (int i = 0; i < NUM_LANES; i++) begin
            exp_w[i] = (i == ch) ? 12'h000 : conv[i];
        end
        words();
        wr(0, DEV_CH_PDN, 32'h0);
        wr(1, HST_CTRL, 32'h1);
        settle();
        chk(32'({lk.fclk_oe, lk.bclk_oe, lk.lane_oe}), 32'h0);
        rd(0, DEV_STATUS);
        chk(v & 32'h5, 32'h5);
        wr(1, HST_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        rd(1, HST_STATUS);
        chk(v & 32'h4, 32'h4);
        wait_rdy();
        wr(1, HST_CTRL, 32'h2);
        settle();
        chk(32'({lk.fclk_oe, lk.lane_oe}), 32'h0);
        rd(0, DEV_STATUS);
        chk(v & 32'h2, 32'h2);
        wr(1, HST_CTRL, 32'h0);
        wait_rdy();
        // a short stop must hold off longer than the long-stop setting used here
        wr(1, HST_CTRL, 32'h2);
        wr(1, HST_CTRL, 32'h0);
        repeat (300) @(posedge clk);
        rd(1, HST_STATUS);
        chk(v & 32'h4, 32'h4);
        wait_rdy();
        wr(0, DEV_CTRL, 32'h32);
        wr(1, HST_CMD, 32'h1);
        settle();
        rd(0, DEV_CTRL);
        chk(v, 32'h0);
        for (int i = 0; i < NUM_LANES; i++) begin
            exp_w[i] = conv[i];
        end
        words();
        summarize();
    end
endmodule : tb
